/* shared/scl_regs.vh */
`ifndef SCL_REGS_VH
`define SCL_REGS_VH

// register byte offsets
`define SCL_OFS_CTL 12'h000
`define SCL_OFS_STS 12'h004
`define SCL_OFS_SWC 12'h008

// bus_control_reg fields
`define SCL_CTL_IGN 16
// bus_status_reg fields
`define SCL_STS_DONE 0
`define SCL_STS_UNM  1
`define SCL_STS_CS   2
`define SCL_STS_NACK 3
`define SCL_STS_LOST 4
`define SCL_STS_MISC 5
// switch_control_reg fields
`define SCL_SWC_HALT 0

// reset values
`define SCL_PRESC_RST 16'h0000
`define SCL_STS_RST   5'h00

// timing: half an scl period in 50 ns core clocks, for 100 KHz and 400 KHz
`define SCL_HALF_SLOW 16'h0064
`define SCL_HALF_FAST 16'h0019

// eeprom bus address high bits 7..5
`define SCL_EE_HI 3'h5
// block types and checks
`define SCL_T_SEQ  2'h1
`define SCL_T_BAD  2'h2
`define SCL_T_DONE 2'h3
`define SCL_SUM_OK 8'hFF
`define SCL_ARB_MAX 5'h10
`endif

/* logic/scl_config_loader.v */
// The register offsets and the AHB-Lite slave port were chosen for this implementation.
`include "scl_regs.vh"
module scl_config_loader #(
  parameter [15:0] EE_MODES = 16'h00FF
) (
  // clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // ahb-lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire        hready,
  input  wire [31:0] hwdata,
  output reg         hreadyout,
  output reg         hresp,
  output reg  [31:0] hrdata,
  // straps and mode
  input  wire        master_slow_mode_strap,
  input  wire [3:0]  eeprom_addr_straps,
  input  wire [3:0]  switch_operating_mode,
  input  wire        hot_reset_req,
  // master smbus pins, open drain
  input  wire        smb_scl_in,
  output wire        smb_scl_out,
  output reg         smb_scl_oe,
  input  wire        smb_sda_in,
  output wire        smb_sda_out,
  output reg         smb_sda_oe,
  // configuration write port
  output reg         cfg_wr_en,
  output reg  [15:0] cfg_wr_addr,
  output reg  [31:0] cfg_wr_data,
  input  wire        cfg_addr_mapped,
  // status
  output reg         reset_halt,
  output reg         eeprom_load_done_flag,
  output reg         io_expander_enable
);

  localparam [4:0] ST_IDLE  = 5'h01;
  localparam [4:0] ST_START = 5'h02;
  localparam [4:0] ST_BYTE  = 5'h04;
  localparam [4:0] ST_STOP  = 5'h08;
  localparam [4:0] ST_FIN   = 5'h10;

  // mode table lookup
  function ee_mode;
    input [3:0] m;
    ee_mode = EE_MODES[m];
  endfunction

  // bytes sent before reading: write addr, pointer hi, lo, read addr
  function [7:0] tx_byte;
    input [1:0] i;
    input [3:0] a;
    case (i)
      2'h0:    tx_byte = {`SCL_EE_HI, a, 1'b0};
      2'h3:    tx_byte = {`SCL_EE_HI, a, 1'b1};
      default: tx_byte = 8'h00;
    endcase
  endfunction

  reg        scl_m, scl_s, scl_d;
  reg        sda_m, sda_s, sda_d;
  reg        slow_m, slow_s;
  reg [3:0]  adr_m, adr_s;
  reg        pin_lvl;
  reg [1:0]  boot;
  reg [15:0] presc;
  reg        ign;
  reg [3:0]  ee_adr;
  reg        dp_wr;
  reg [11:0] dp_ofs;
  reg [31:0] rd_val;
  reg [5:1]  sts_err;
  reg [4:0]  st;
  reg [1:0]  sub;
  reg        ph;
  reg [3:0]  bcnt;
  reg [1:0]  txi;
  reg        rd;
  reg [7:0]  sh;
  reg [7:0]  rx_byte;
  reg [15:0] tmr;
  reg [4:0]  arb_cnt;
  reg        byte_ev, restart, fin_ev;
  reg        ev_nack, ev_lost, ev_misc, ev_cs, ev_unm;
  reg [7:0]  sum;
  reg [2:0]  pidx;
  reg [1:0]  btype;
  reg [13:0] waddr;
  reg [15:0] wcnt;
  reg [31:0] wdat;
  reg [15:0] ee_ptr;
  reg        stop_rd;
  reg        wr_pend;

  wire       idle    = (st == ST_IDLE);
  wire       go      = ee_mode(switch_operating_mode) &&
                       ((boot == 2'h2) || (hot_reset_req && boot == 2'h3 && idle));
  wire       ap      = hsel && htrans[1] && hready;
  wire       stall   = ~smb_scl_oe && ~scl_s; // slave stretching the clock
  wire       tick    = (tmr == presc - 16'h0001);
  wire [7:0] nsum    = sum + rx_byte;
  wire       err_any = ev_nack | ev_lost | ev_misc | ev_cs;
  wire [5:1] sts_clr = (dp_wr && dp_ofs == `SCL_OFS_STS) ? hwdata[5:1] : `SCL_STS_RST;
  wire       halt_clr = dp_wr && dp_ofs == `SCL_OFS_SWC && hwdata[`SCL_SWC_HALT];

  // pins only ever pull low
  assign smb_scl_out = pin_lvl;
  assign smb_sda_out = pin_lvl;

  // two-flop synchronisers for pins and straps
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_m  <= 1'b1;
      scl_s  <= 1'b1;
      scl_d  <= 1'b1;
      sda_m  <= 1'b1;
      sda_s  <= 1'b1;
      sda_d  <= 1'b1;
      slow_m <= 1'b0;
      slow_s <= 1'b0;
      adr_m  <= 4'h0;
      adr_s  <= 4'h0;
    end else begin
      scl_m  <= smb_scl_in;
      scl_s  <= scl_m;
      scl_d  <= scl_s;
      sda_m  <= smb_sda_in;
      sda_s  <= sda_m;
      sda_d  <= sda_s;
      slow_m <= master_slow_mode_strap;
      slow_s <= slow_m;
      adr_m  <= eeprom_addr_straps;
      adr_s  <= adr_m;
    end
  end

  // register read mux, addressed in the address phase
  always @* begin
    rd_val = 32'h0000_0000;
    case (haddr[11:0])
      `SCL_OFS_CTL: rd_val = {15'h0000, ign, presc};
      `SCL_OFS_STS: rd_val = {26'h0000000, sts_err, eeprom_load_done_flag};
      `SCL_OFS_SWC: rd_val = {31'h00000000, reset_halt};
      default:      rd_val = 32'h0000_0000;
    endcase
  end

  // bus slave, zero wait states, control register and strap capture
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
      dp_wr     <= 1'b0;
      dp_ofs    <= 12'h000;
      pin_lvl   <= 1'b0;
      boot      <= 2'h0;
      presc     <= `SCL_PRESC_RST;
      ign       <= 1'b0;
      ee_adr    <= 4'h0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      pin_lvl   <= 1'b0;
      dp_wr     <= ap && hwrite;
      dp_ofs    <= haddr[11:0];
      if (ap && !hwrite)
        hrdata <= rd_val;
      if (boot != 2'h3)
        boot <= boot + 2'h1;
      // strap is caught once the synchroniser holds it
      if (boot == 2'h2)
        presc <= slow_s ? `SCL_HALF_SLOW : `SCL_HALF_FAST;
      else if (dp_wr && dp_ofs == `SCL_OFS_CTL) begin
        presc <= hwdata[15:0];
        ign   <= hwdata[`SCL_CTL_IGN];
      end
      if (go)
        ee_adr <= adr_s;
    end
  end

  // sticky status, set wins over a write-one-to-clear
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sts_err               <= `SCL_STS_RST;
      eeprom_load_done_flag <= 1'b0;
      reset_halt            <= 1'b0;
      io_expander_enable    <= 1'b0;
    end else begin
      sts_err <= (sts_err & ~sts_clr) | {ev_misc, ev_lost, ev_nack, ev_cs, ev_unm};
      if (go)
        eeprom_load_done_flag <= 1'b0;
      else if (fin_ev)
        eeprom_load_done_flag <= 1'b1;
      reset_halt <= (reset_halt & ~halt_clr) | err_any;
      io_expander_enable <= (boot == 2'h3) && idle && !go;
    end
  end

  // smbus bit engine and transaction sequencer
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st         <= ST_IDLE;
      sub        <= 2'h0;
      ph         <= 1'b0;
      bcnt       <= 4'h0;
      txi        <= 2'h0;
      rd         <= 1'b0;
      sh         <= 8'h00;
      rx_byte    <= 8'h00;
      tmr        <= 16'h0000;
      arb_cnt    <= 5'h00;
      smb_scl_oe <= 1'b0;
      smb_sda_oe <= 1'b0;
      byte_ev    <= 1'b0;
      restart    <= 1'b0;
      fin_ev     <= 1'b0;
      ev_nack    <= 1'b0;
      ev_lost    <= 1'b0;
      ev_misc    <= 1'b0;
    end else begin
      byte_ev <= 1'b0;
      restart <= 1'b0;
      fin_ev  <= 1'b0;
      ev_nack <= 1'b0;
      ev_lost <= 1'b0;
      ev_misc <= 1'b0;
      // half-period timer holds while the clock is stretched
      if (tick || go)
        tmr <= 16'h0000;
      else if (!stall)
        tmr <= tmr + 16'h0001;
      case (st)
        ST_IDLE: begin
          if (go) begin
            st         <= ST_START;
            sub        <= 2'h0;
            txi        <= 2'h0;
            rd         <= 1'b0;
            arb_cnt    <= 5'h00;
            smb_sda_oe <= 1'b0;
          end
        end
        ST_START: begin
          // release data, release clock, pull data, then pull clock
          if (tick) begin
            sub <= sub + 2'h1;
            case (sub)
              2'h0: smb_scl_oe <= 1'b0;
              2'h1: smb_sda_oe <= 1'b1;
              default: begin
                smb_scl_oe <= 1'b1;
                st         <= ST_BYTE;
                sh         <= tx_byte(txi, ee_adr);
                bcnt       <= 4'h0;
                ph         <= 1'b0;
              end
            endcase
          end
        end
        ST_BYTE: begin
          if (!ph) begin
            // data only moves while the clock is low
            if (bcnt == 4'h8)
              smb_sda_oe <= rd ? ~stop_rd : 1'b0;
            else
              smb_sda_oe <= rd ? 1'b0 : ~sh[7];
            if (tick) begin
              smb_scl_oe <= 1'b0;
              ph         <= 1'b1;
            end
          end else if (scl_s && scl_d && sda_s != sda_d) begin
            ev_misc    <= 1'b1;
            smb_scl_oe <= 1'b0;
            smb_sda_oe <= 1'b0;
            st         <= ST_FIN;
          end else if (tick) begin
            smb_scl_oe <= 1'b1;
            ph         <= 1'b0;
            bcnt       <= bcnt + 4'h1;
            if (bcnt != 4'h8) begin
              sh <= {sh[6:0], sda_s};
              if (rd && bcnt == 4'h7) begin
                rx_byte <= {sh[6:0], sda_s};
                byte_ev <= 1'b1;
              end
              if (!rd && sh[7] && !sda_s) begin
                // another master won the bus: back off and retry
                smb_scl_oe <= 1'b0;
                smb_sda_oe <= 1'b0;
                arb_cnt    <= arb_cnt + 5'h01;
                if (arb_cnt + 5'h01 == `SCL_ARB_MAX) begin
                  ev_lost <= 1'b1;
                  st      <= ST_FIN;
                end else begin
                  restart <= 1'b1;
                  st      <= ST_START;
                  sub     <= 2'h0;
                  txi     <= 2'h0;
                end
              end
            end else if (!rd) begin
              if (sda_s) begin
                ev_nack    <= 1'b1;
                st         <= ST_STOP;
                sub        <= 2'h0;
              end else begin
                arb_cnt <= 5'h00;
                txi     <= txi + 2'h1;
                bcnt    <= 4'h0;
                sh      <= tx_byte(txi + 2'h1, ee_adr);
                if (txi == 2'h2) begin
                  // repeated start turns the bus round for reading
                  st         <= ST_START;
                  sub        <= 2'h0;
                  smb_sda_oe <= 1'b0;
                end
                if (txi == 2'h3)
                  rd <= 1'b1;
              end
            end else if (stop_rd) begin
              st         <= ST_STOP;
              sub        <= 2'h0;
            end else
              bcnt <= 4'h0;
          end
        end
        ST_STOP: begin
          // data falls only once the clock is low, so no false start
          if (tick) begin
            sub <= sub + 2'h1;
            case (sub)
              2'h0: smb_sda_oe <= 1'b1;
              2'h1: smb_scl_oe <= 1'b0;
              2'h2: smb_sda_oe <= 1'b0;
              default: st <= ST_FIN;
            endcase
          end
        end
        ST_FIN: begin
          fin_ev <= 1'b1;
          st     <= ST_IDLE;
        end
        default: st <= ST_IDLE;
      endcase
    end
  end

  // block parser, checksum and register writes
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sum         <= 8'h00;
      pidx        <= 3'h0;
      btype       <= 2'h0;
      waddr       <= 14'h0000;
      wcnt        <= 16'h0000;
      wdat        <= 32'h0000_0000;
      ee_ptr      <= 16'h0000;
      stop_rd     <= 1'b0;
      wr_pend     <= 1'b0;
      cfg_wr_en   <= 1'b0;
      cfg_wr_addr <= 16'h0000;
      cfg_wr_data <= 32'h0000_0000;
      ev_cs       <= 1'b0;
      ev_unm      <= 1'b0;
    end else begin
      cfg_wr_en <= 1'b0;
      ev_cs     <= 1'b0;
      ev_unm    <= 1'b0;
      // address decode answers one cycle after it is presented
      if (wr_pend) begin
        wr_pend <= 1'b0;
        if (cfg_addr_mapped)
          cfg_wr_en <= 1'b1;
        else
          ev_unm <= 1'b1;
      end
      if (go || restart) begin
        sum     <= 8'h00;
        pidx    <= 3'h0;
        ee_ptr  <= 16'h0000;
        stop_rd <= 1'b0;
      end else if (byte_ev) begin
        sum    <= nsum;
        ee_ptr <= ee_ptr + 16'h0001;
        if (ee_ptr == 16'hFFFF)
          stop_rd <= 1'b1;
        case (pidx)
          3'h0: begin
            btype       <= rx_byte[1:0];
            waddr[5:0]  <= rx_byte[7:2];
            pidx        <= 3'h1;
            if (rx_byte[1:0] == `SCL_T_BAD) begin
              ev_cs   <= 1'b1;
              stop_rd <= 1'b1;
            end
          end
          3'h1: begin
            if (btype == `SCL_T_DONE) begin
              stop_rd <= 1'b1;
              if (nsum != `SCL_SUM_OK && !ign)
                ev_cs <= 1'b1;
            end else begin
              waddr[13:6] <= rx_byte;
              wcnt        <= 16'h0001;
              pidx        <= (btype == `SCL_T_SEQ) ? 3'h2 : 3'h4;
            end
          end
          3'h2: begin
            wcnt[7:0] <= rx_byte;
            pidx      <= 3'h3;
          end
          3'h3: begin
            wcnt[15:8] <= rx_byte;
            pidx       <= ({rx_byte, wcnt[7:0]} == 16'h0000) ? 3'h0 : 3'h4;
          end
          default: begin
            wdat <= {rx_byte, wdat[31:8]};
            pidx <= pidx + 3'h1;
            if (pidx == 3'h7) begin
              // whole dword assembled: present it for decode
              wr_pend     <= 1'b1;
              cfg_wr_addr <= {waddr, 2'b00};
              cfg_wr_data <= {rx_byte, wdat[31:8]};
              waddr       <= waddr + 14'h0001;
              wcnt        <= wcnt - 16'h0001;
              pidx        <= (wcnt == 16'h0001) ? 3'h0 : 3'h4;
            end
          end
        endcase
      end
    end
  end

endmodule

/* testbench/scl_config_loader_checker.sv */
module scl_config_loader_checker (
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // smbus enables
  input wire logic        smb_scl_oe,
  input wire logic        smb_sda_oe,
  // configuration writes
  input wire logic        cfg_wr_en,
  input wire logic [15:0] cfg_wr_addr,
  input wire logic        cfg_addr_mapped,
  // status
  input wire logic        reset_halt,
  input wire logic        eeprom_load_done_flag,
  input wire logic        io_expander_enable
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // writes are whole aligned dwords, one pulse each
  a_cfg_align: assert property (cfg_wr_en |-> cfg_wr_addr[1:0] == 2'h0)
    else $error("cfg write address not dword aligned");
  a_wr_single: assert property (cfg_wr_en |=> !cfg_wr_en)
    else $error("cfg write pulse longer than one cycle");
  a_unmapped_drop: assert property (cfg_wr_en |-> cfg_addr_mapped)
    else $error("write issued to unmapped address");
  // expander side stays shut while the loader owns the bus
  a_expander_wait: assert property (cfg_wr_en |-> !io_expander_enable)
    else $error("expander enabled during load");
  a_bus_quiet: assert property (io_expander_enable |-> !smb_scl_oe && !smb_sda_oe)
    else $error("loader drives bus after load");
  // errors other than an unmapped write end the load and block further writes
  a_halt_done: assert property ($rose(reset_halt) |-> ##[0:1000] eeprom_load_done_flag)
    else $error("halt without done");
  a_halt_no_write: assert property (reset_halt |-> !cfg_wr_en)
    else $error("cfg write while halted");
  a_done_released: assert property ($rose(eeprom_load_done_flag) |-> !smb_scl_oe && !smb_sda_oe)
    else $error("done while bus still driven");

  c_write: cover property (cfg_wr_en);
  c_halt: cover property ($rose(reset_halt));
  c_clean_done: cover property ($rose(eeprom_load_done_flag) && !reset_halt);
endmodule

/* testbench/scl_eeprom_model.sv */
module scl_eeprom_model (
  // bus wires
  input wire logic       scl,
  input wire logic       sda,
  // setup
  input wire logic       present,
  input wire logic [3:0] straps,
  output logic           sda_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  mem [0:255];
  logic [7:0]  sh;
  logic [3:0]  n;
  logic [1:0]  ph;
  logic [15:0] ptr;
  logic        act, rd;
  wire  [7:0]  cur = mem[ptr[7:0]];

  initial begin
    sda_oe = 1'b0;
    act = 1'b0;
    n = 4'h0;
    ph = 2'h0;
    rd = 1'b0;
    ptr = 16'h0000;
  end
  // start or repeated start, stop
  always @(negedge sda) if (scl) begin
    act = 1'b1;
    n = 4'h0;
    ph = 2'h0;
    rd = 1'b0;
  end
  always @(posedge sda) if (scl) begin
    act = 1'b0;
    sda_oe = 1'b0;
  end
  // bits in; master nack ends a read
  always @(posedge scl) if (act) begin
    if (n < 8) begin
      sh = {sh[6:0], sda};
      n = n + 4'h1;
    end else begin
      n = 4'h0;
      if (rd && ph == 2'h3 && sda) act = 1'b0;
    end
  end
  // only change sda while scl is low
  always @(negedge scl) if (act) begin
    if (n == 8 && ph == 2'h0) begin
      sda_oe = present && sh[7:1] == {3'h5, straps};
      rd = sh[0];
      ph = sh[0] ? 2'h3 : 2'h1;
      if (!sda_oe) act = 1'b0;
    end else if (n == 8 && !rd) begin
      sda_oe = 1'b1;
      if (ph == 2'h1) ptr[15:8] = sh;
      else ptr[7:0] = sh;
      ph = 2'h2;
    end else if (n == 8) begin
      sda_oe = 1'b0;
      ptr = ptr + 16'h0001;
    end else begin
      sda_oe = rd && ph == 2'h3 && !cur[7 - n];
    end
  end
endmodule

/* testbench/scl_config_loader_tb.sv */
`include "scl_regs.vh"
module scl_config_loader_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        hclk, hresetn, hsel, hwrite, hot, slow, present, jam;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  mode, straps;
  logic [31:0] haddr, hwdata, hrdata, r, wr_data;
  logic        hreadyout, hresp, scl_oe, sda_oe, ee_oe, wr_en, halt, done, ioe;
  logic [15:0] wr_addr;
  logic [7:0]  sum;
  logic [47:0] wq[$];
  int          ni, miscompares, compares;
  // open-drain wires with pull-ups
  wire         scl = !scl_oe;
  wire         sda = !(sda_oe | ee_oe | jam); // jam stands for a rival master

  scl_config_loader uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .master_slow_mode_strap(slow), .eeprom_addr_straps(straps),
    .switch_operating_mode(mode), .hot_reset_req(hot),
    .smb_scl_in(scl), .smb_scl_out(), .smb_scl_oe(scl_oe),
    .smb_sda_in(sda), .smb_sda_out(), .smb_sda_oe(sda_oe),
    .cfg_wr_en(wr_en), .cfg_wr_addr(wr_addr), .cfg_wr_data(wr_data),
    .cfg_addr_mapped(wr_addr[15:12] != 4'hF),
    .reset_halt(halt), .eeprom_load_done_flag(done), .io_expander_enable(ioe)
  );
  scl_eeprom_model ee (
    .scl(scl), .sda(sda), .present(present), .straps(straps), .sda_oe(ee_oe)
  );

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  // log every configuration write
  always @(posedge hclk) if (wr_en === 1'b1) wq.push_back({wr_addr, wr_data});

  task check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // single word transfer, held until hready is sampled high
  task ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h00000, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  // image building; bytes are summed for the checksum
  task put(input logic [7:0] b);
    ee.mem[ni] = b;
    sum = sum + b;
    ni++;
  endtask
  task blk(input logic [13:0] a, input logic [1:0] t);
    put({a[5:0], t});
    put(a[13:6]);
  endtask
  task dw(input logic [31:0] d);
    for (int i = 0; i < 4; i++) put(d[8*i +: 8]);
  endtask
  task img(input logic [1:0] t);
    foreach (ee.mem[i]) ee.mem[i] = 8'hFF;
    ni = 0;
    sum = 8'h00;
    blk(14'h0010, 2'h0);
    dw(32'h1122_3344);
    blk(14'h0100, t);
  endtask
  task fin(input logic [7:0] adj);
    put(8'h03);
    put(~sum + adj);
  endtask
  // load after reset can take a long time at bus speed
  task wait_idle;
    repeat (3) @(posedge hclk);
    for (int i = 0; i < 40000 && ioe !== 1'b1; i++) @(posedge hclk);
    check("idle", ioe, 1'b1);
    repeat (5) @(posedge hclk);
  endtask
  task boot;
    wq.delete();
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    wait_idle;
  endtask
  task st(input string t, input logic [5:0] s, input logic h);
    ahb(1'b0, `SCL_OFS_STS, 32'h0);
    check("resp", hresp, 1'b0);
    check("status", r[5:0], s);
    check("halt", halt, h);
    check("done", done, 1'b1);
    $display("test %s finished", t);
  endtask

  task t_good;
    img(2'h1);
    put(8'h02);
    put(8'h00);
    dw(32'hA5A5_0001);
    dw(32'h5A5A_0002);
    blk(14'h3C01, 2'h0);
    dw(32'hDEAD_BEEF);
    fin(8'h00);
    boot;
    check("writes", wq.size(), 3);
    check("w0", wq[0], {16'h0040, 32'h1122_3344});
    check("w1", wq[1], {16'h0400, 32'hA5A5_0001});
    check("w2", wq[2], {16'h0404, 32'h5A5A_0002});
    ahb(1'b0, `SCL_OFS_CTL, 32'h0);
    check("presc", r[15:0], 16'h0019);
    st("good", 6'h03, 1'b0);
  endtask
  task t_badtype;
    img(2'h2);
    straps <= 4'h5; // second strap pattern
    fin(8'h00);
    boot;
    check("writes", wq.size(), 1);
    st("badtype", 6'h05, 1'b1);
    ahb(1'b1, `SCL_OFS_SWC, 32'h1);
    ahb(1'b1, `SCL_OFS_STS, 32'h3E);
    check("halt clr", halt, 1'b0);
    ahb(1'b0, `SCL_OFS_STS, 32'h0);
    check("sts clr", r[5:0], 6'h01);
  endtask
  task t_sum;
    img(2'h3);
    ni = ni - 2;
    sum = sum - 8'h01;
    fin(8'h01);
    boot;
    st("badsum", 6'h05, 1'b1);
    ahb(1'b1, `SCL_OFS_CTL, 32'h0001_0019);
    ahb(1'b1, `SCL_OFS_SWC, 32'h1);
    ahb(1'b1, `SCL_OFS_STS, 32'h3E);
    @(posedge hclk);
    hot <= 1'b1;
    @(posedge hclk);
    hot <= 1'b0;
    for (int i = 0; i < 20 && ioe !== 1'b0; i++) @(posedge hclk);
    wait_idle;
    check("writes", wq.size(), 2);
    st("ignore", 6'h01, 1'b0);
  endtask
  task t_mode;
    mode <= 4'h8;
    boot;
    check("expander", ioe, 1'b1);
    check("writes", wq.size(), 0);
    $display("test mode finished");
    mode <= 4'h0;
  endtask
  task t_absent;
    present <= 1'b0;
    slow <= 1'b1;
    boot;
    ahb(1'b0, `SCL_OFS_CTL, 32'h0);
    check("presc", r[15:0], 16'h0064);
    st("absent", 6'h09, 1'b1);
  endtask
  // data pulled low mid-bit while the clock is high is misplaced
  task t_misc;
    @(posedge hclk);
    hot <= 1'b1;
    @(posedge hclk);
    hot <= 1'b0;
    do @(posedge hclk); while (scl_oe !== 1'b1);
    do @(posedge hclk); while (scl_oe !== 1'b0);
    repeat (5) @(posedge hclk);
    jam <= 1'b1;
    repeat (5) @(posedge hclk);
    jam <= 1'b0;
    wait_idle;
    st("misc", 6'h23, 1'b1);
  endtask
  // a rival master holding data low wins every arbitration
  task t_lost;
    jam <= 1'b1;
    boot;
    jam <= 1'b0;
    st("lost", 6'h11, 1'b1);
  endtask

  task print_verdict;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // watchdog, near twice the expected run
  initial begin
    repeat (80000) @(posedge hclk);
    miscompares++;
    print_verdict;
  end
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    hot = 1'b0;
    slow = 1'b0;
    present = 1'b1;
    jam = 1'b0;
    straps = 4'hA;
    htrans = 2'h0;
    hsize = 3'h2;
    mode = 4'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    miscompares = 0;
    compares = 0;
    t_good;
    t_misc;
    t_badtype;
    t_sum;
    t_mode;
    t_absent;
    t_lost;
    print_verdict;
  end
endmodule
bind scl_config_loader scl_config_loader_checker chk (
  .hclk(hclk), .hresetn(hresetn), .smb_scl_oe(smb_scl_oe), .smb_sda_oe(smb_sda_oe),
  .cfg_wr_en(cfg_wr_en), .cfg_wr_addr(cfg_wr_addr), .cfg_addr_mapped(cfg_addr_mapped),
  .reset_halt(reset_halt), .eeprom_load_done_flag(eeprom_load_done_flag),
  .io_expander_enable(io_expander_enable)
);
